/* File: shared/wire_link_pkg.sv */
// shared constants for the single-wire slot signalling link
package wire_link_pkg;

    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 20;

    // ------------------------------------------------------------
    // times in microseconds
    // ------------------------------------------------------------
    localparam int RESET_LOW_US     = 480;
    localparam int RESET_DETECT_US  = 440;
    localparam int PRES_WAIT_US     = 30;
    localparam int PRES_LEN_US      = 120;
    localparam int PRES_SAMPLE_US   = 70;
    localparam int SLOT_US          = 65;
    localparam int WRITE1_LOW_US    = 6;
    localparam int READ_LOW_US      = 2;
    localparam int MASTER_SAMPLE_US = 12;
    localparam int RECOVER_US       = 5;
    localparam int SLAVE_SAMPLE_US  = 30;
    localparam int SLAVE_DRIVE_US   = 30;
    localparam int SLAVE_SLOT_US    = 50;

    // ------------------------------------------------------------
    // times in clock cycles
    // ------------------------------------------------------------
    localparam int RESET_LOW_CYC     = RESET_LOW_US * CLK_MHZ;
    localparam int RESET_DETECT_CYC  = RESET_DETECT_US * CLK_MHZ;
    localparam int PRES_WAIT_CYC     = PRES_WAIT_US * CLK_MHZ;
    localparam int PRES_LEN_CYC      = PRES_LEN_US * CLK_MHZ;
    localparam int PRES_SAMPLE_CYC   = PRES_SAMPLE_US * CLK_MHZ;
    localparam int SLOT_CYC          = SLOT_US * CLK_MHZ;
    localparam int WRITE1_LOW_CYC    = WRITE1_LOW_US * CLK_MHZ;
    localparam int READ_LOW_CYC      = READ_LOW_US * CLK_MHZ;
    localparam int MASTER_SAMPLE_CYC = MASTER_SAMPLE_US * CLK_MHZ;
    localparam int RECOVER_CYC       = RECOVER_US * CLK_MHZ;
    localparam int SLAVE_SAMPLE_CYC  = SLAVE_SAMPLE_US * CLK_MHZ;
    localparam int SLAVE_DRIVE_CYC   = SLAVE_DRIVE_US * CLK_MHZ;
    localparam int SLAVE_SLOT_CYC    = SLAVE_SLOT_US * CLK_MHZ;

    // ------------------------------------------------------------
    // master operations, check polynomial, reset values
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_RESET  = 2'h0,
        OP_WRITE  = 2'h1,
        OP_READ   = 2'h2,
        OP_PULLUP = 2'h3
    } op_e;

    localparam logic [7:0] CRC_POLY  = 8'h8C;
    localparam logic [7:0] CRC_RESET = 8'h00;
    localparam logic [7:0] BYTE_LAST = 8'h07;

endpackage

/* File: shared/wire_link_if.sv */
// open-drain single wire shared by master and slave
`timescale 1ns/1ps
interface wire_link_if;
    logic masterOut;
    logic masterOe;
    logic slaveOut;
    logic slaveOe;
    logic strongPullup;
    logic busLevel;

    // wired-AND: any driver that is enabled and outputs low pulls the line low
    assign busLevel = !(masterOe && !masterOut) && !(slaveOe && !slaveOut);

    modport master (output masterOut, output masterOe, output strongPullup, input busLevel);
    modport slave  (output slaveOut, output slaveOe, input busLevel);
endinterface

/* File: rtl/slot_master.sv */
// bus master end: reset/presence, byte write and read slots, strong pullup, check byte
`timescale 1ns/1ps
module slot_master #(
    parameter int RESET_LOW_CYCLES = wire_link_pkg::RESET_LOW_CYC
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // command side
    input  wire logic       cmdValid,
    input  wire logic [1:0] cmdOp,
    input  wire logic [7:0] cmdData,
    output logic            cmdReady,
    // answer side
    output logic            doneValid,
    output logic [7:0]      doneData,
    output logic            presenceSeen,
    output logic            crcZero,
    // the wire
    wire_link_if.master     link
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_RST_LOW, ST_RST_LISTEN, ST_SLOT, ST_RECOVER} mstate_e;

    mstate_e     state_reg;
    logic [15:0] cnt_reg;
    logic [7:0]  shift_reg;
    logic [2:0]  bitIdx_reg;
    logic        isRead_reg;
    logic [7:0]  crc_reg;
    logic        oe_reg;
    logic        spu_reg;
    logic        busMeta_reg;
    logic        busSync_reg;
    logic        crcFb;

    // ------------------------------------------------------------
    // bus input synchroniser
    // ------------------------------------------------------------
    // the line is asynchronous to mclk: two flops before any logic
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            busMeta_reg <= 1'b1;
            busSync_reg <= 1'b1;
        end else begin
            busMeta_reg <= link.busLevel;
            busSync_reg <= busMeta_reg;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    assign crcFb = crc_reg[0] ^ busSync_reg;

    // one counter times every phase; a new op is only taken in idle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg    <= ST_IDLE;
            cnt_reg      <= 16'h0000;
            shift_reg    <= 8'h00;
            bitIdx_reg   <= 3'h0;
            isRead_reg   <= 1'b0;
            crc_reg      <= wire_link_pkg::CRC_RESET;
            presenceSeen <= 1'b0;
            doneValid    <= 1'b0;
            doneData     <= 8'h00;
        end else begin
            doneValid <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 16'h0000;
                    if (cmdValid) begin
                        case (wire_link_pkg::op_e'(cmdOp))
                            wire_link_pkg::OP_RESET: begin
                                state_reg    <= ST_RST_LOW;
                                presenceSeen <= 1'b0;
                                crc_reg      <= wire_link_pkg::CRC_RESET;
                            end
                            wire_link_pkg::OP_WRITE,
                            wire_link_pkg::OP_READ: begin
                                state_reg  <= ST_SLOT;
                                shift_reg  <= cmdData;
                                isRead_reg <= (cmdOp == 2'(wire_link_pkg::OP_READ));
                                bitIdx_reg <= 3'h0;
                            end
                            default: begin
                                doneValid <= 1'b1;                          // pullup taken at once
                            end
                        endcase
                    end
                end
                ST_RST_LOW: begin
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg == 16'(RESET_LOW_CYCLES - 1)) begin
                        state_reg <= ST_RST_LISTEN;
                        cnt_reg   <= 16'h0000;
                    end
                end
                ST_RST_LISTEN: begin
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg == 16'(wire_link_pkg::PRES_SAMPLE_CYC)) begin
                        presenceSeen <= !busSync_reg;
                    end
                    if (cnt_reg == 16'(RESET_LOW_CYCLES - 1)) begin
                        state_reg <= ST_IDLE;
                        doneValid <= 1'b1;
                    end
                end
                ST_SLOT: begin
                    cnt_reg <= cnt_reg + 16'h0001;
                    // sample late in the 15us window for margin
                    if (isRead_reg && cnt_reg == 16'(wire_link_pkg::MASTER_SAMPLE_CYC)) begin
                        shift_reg <= {busSync_reg, shift_reg[7:1]};
                        crc_reg   <= (crc_reg >> 1) ^ (crcFb ? wire_link_pkg::CRC_POLY : 8'h00);
                    end
                    if (cnt_reg == 16'(wire_link_pkg::SLOT_CYC - 1)) begin
                        state_reg <= ST_RECOVER;
                        cnt_reg   <= 16'h0000;
                        if (!isRead_reg) begin
                            shift_reg <= {1'b0, shift_reg[7:1]};
                        end
                    end
                end
                ST_RECOVER: begin
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg == 16'(wire_link_pkg::RECOVER_CYC - 1)) begin
                        cnt_reg <= 16'h0000;
                        if (bitIdx_reg == wire_link_pkg::BYTE_LAST[2:0]) begin
                            state_reg <= ST_IDLE;
                            doneValid <= 1'b1;
                            doneData  <= shift_reg;
                        end else begin
                            bitIdx_reg <= bitIdx_reg + 3'h1;
                            state_reg  <= ST_SLOT;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // line drive
    // ------------------------------------------------------------
    // only ever pull low or let go; the output value itself stays 0
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            oe_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_RST_LOW: oe_reg <= 1'b1;
                ST_SLOT: begin
                    if (isRead_reg) begin
                        oe_reg <= cnt_reg < 16'(wire_link_pkg::READ_LOW_CYC);
                    end else if (shift_reg[0]) begin
                        oe_reg <= cnt_reg < 16'(wire_link_pkg::WRITE1_LOW_CYC);
                    end else begin
                        oe_reg <= cnt_reg < 16'(wire_link_pkg::SLOT_CYC);
                    end
                end
                default: oe_reg <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // strong pullup, ready and check flag
    // ------------------------------------------------------------
    // pullup stays on until the next op is taken, so the user times the conversion
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            spu_reg  <= 1'b0;
            cmdReady <= 1'b0;
            crcZero  <= 1'b1;
        end else begin
            cmdReady <= (state_reg == ST_IDLE) && !cmdValid;
            crcZero  <= (crc_reg == 8'h00);
            if (state_reg == ST_IDLE && cmdValid) begin
                spu_reg <= (cmdOp == 2'(wire_link_pkg::OP_PULLUP));
            end
        end
    end

    assign link.masterOut    = 1'b0;
    assign link.masterOe     = oe_reg;
    assign link.strongPullup = spu_reg;

endmodule // slot_master

/* File: rtl/slot_slave.sv */
// slave end: reset detection, presence pulse, write sampling and read answers
`timescale 1ns/1ps
module slot_slave #(
    parameter int RESET_DETECT_CYCLES = wire_link_pkg::RESET_DETECT_CYC
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // user side
    input  wire logic sendEn,
    input  wire logic sendBit,
    input  wire logic pollMode,
    input  wire logic opBusy,
    output logic      rxValid,
    output logic      rxBit,
    output logic      resetSeen,
    output logic      linkReady,
    // the wire
    wire_link_if.slave link
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {SS_WAIT_RST, SS_RST_LOW, SS_PRES_WAIT, SS_PRES, SS_READY, SS_SLOT} sstate_e;

    sstate_e     state_reg;
    logic [15:0] cnt_reg;
    logic [15:0] lowCnt_reg;
    logic        busMeta_reg;
    logic        busSync_reg;
    logic        busPrev_reg;
    logic        txNow_reg;
    logic        txBit_reg;
    logic        oe_reg;
    logic        longLow;

    // ------------------------------------------------------------
    // bus synchroniser and low timer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            busMeta_reg <= 1'b1;
            busSync_reg <= 1'b1;
            busPrev_reg <= 1'b1;
            lowCnt_reg  <= 16'h0000;
        end else begin
            busMeta_reg <= link.busLevel;
            busSync_reg <= busMeta_reg;
            busPrev_reg <= busSync_reg;
            if (busSync_reg) begin
                lowCnt_reg <= 16'h0000;
            end else if (lowCnt_reg != 16'hFFFF) begin
                lowCnt_reg <= lowCnt_reg + 16'h0001;
            end
        end
    end

    assign longLow = (lowCnt_reg == 16'(RESET_DETECT_CYCLES - 1));

    // ------------------------------------------------------------
    // slot sequencer
    // ------------------------------------------------------------
    // a long low overrides any state, so a broken byte never wedges the link
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg <= SS_WAIT_RST;
            cnt_reg   <= 16'h0000;
            txNow_reg <= 1'b0;
            txBit_reg <= 1'b1;
            rxValid   <= 1'b0;
            rxBit     <= 1'b0;
            resetSeen <= 1'b0;
        end else begin
            rxValid   <= 1'b0;
            resetSeen <= 1'b0;
            if (longLow) begin
                state_reg <= SS_RST_LOW;
                resetSeen <= 1'b1;
            end else begin
                case (state_reg)
                    SS_WAIT_RST: cnt_reg <= 16'h0000;
                    SS_RST_LOW: begin
                        cnt_reg <= 16'h0000;
                        if (busSync_reg && !busPrev_reg) begin
                            state_reg <= SS_PRES_WAIT;
                        end
                    end
                    SS_PRES_WAIT: begin
                        cnt_reg <= cnt_reg + 16'h0001;
                        if (cnt_reg == 16'(wire_link_pkg::PRES_WAIT_CYC - 1)) begin
                            state_reg <= SS_PRES;
                            cnt_reg   <= 16'h0000;
                        end
                    end
                    SS_PRES: begin
                        cnt_reg <= cnt_reg + 16'h0001;
                        if (cnt_reg == 16'(wire_link_pkg::PRES_LEN_CYC - 1)) begin
                            state_reg <= SS_READY;
                        end
                    end
                    SS_READY: begin
                        cnt_reg <= 16'h0000;
                        if (!busSync_reg && busPrev_reg) begin
                            state_reg <= SS_SLOT;
                            txNow_reg <= sendEn;
                            txBit_reg <= pollMode ? !opBusy : sendBit;
                        end
                    end
                    SS_SLOT: begin
                        cnt_reg <= cnt_reg + 16'h0001;
                        if (cnt_reg == 16'(wire_link_pkg::SLAVE_SAMPLE_CYC) && !txNow_reg) begin
                            rxBit   <= busSync_reg;
                            rxValid <= 1'b1;
                        end
                        if (cnt_reg == 16'(wire_link_pkg::SLAVE_SLOT_CYC - 1)) begin
                            state_reg <= SS_READY;
                        end
                    end
                    default: state_reg <= SS_WAIT_RST;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // line drive
    // ------------------------------------------------------------
    // presence is the only thing the slave starts by itself
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            oe_reg    <= 1'b0;
            linkReady <= 1'b0;
        end else begin
            linkReady <= (state_reg == SS_READY) || (state_reg == SS_SLOT);
            if (longLow) begin
                oe_reg <= 1'b0;
            end else begin
                case (state_reg)
                    SS_PRES: oe_reg <= 1'b1;
                    SS_SLOT: oe_reg <= txNow_reg && !txBit_reg &&
                                       cnt_reg < 16'(wire_link_pkg::SLAVE_DRIVE_CYC);
                    default: oe_reg <= 1'b0;
                endcase
            end
        end
    end

    assign link.slaveOut = 1'b0;
    assign link.slaveOe  = oe_reg;

endmodule // slot_slave

/* File: sim/wire_link_monitor.sv */
// property checker watching the shared single wire between master and slave
`timescale 1ns/1ps
module wire_link_monitor #(
    parameter int RESET_LOW_CYCLES = wire_link_pkg::RESET_LOW_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // wire signals
    input wire logic masterOut,
    input wire logic masterOe,
    input wire logic slaveOut,
    input wire logic slaveOe,
    input wire logic strongPullup,
    input wire logic busLevel
);
    localparam int US       = wire_link_pkg::CLK_MHZ;
    localparam int LONG_LOW = 2 * wire_link_pkg::SLOT_CYC;
    int lowCnt;  // cycles the master has held the line low
    int relCnt;  // cycles the master has left the line released
    int slvCnt;  // cycles the slave has held the line low
    int lastLen; // length of the latest master low pulse

    // ------------------------------------------------------------
    // pulse length counters, sampled on the first cycle after a pulse
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            lowCnt <= 0;
        else
            lowCnt <= masterOe ? lowCnt + 1 : 0;
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            relCnt <= 0;
        else
            relCnt <= masterOe ? 0 : relCnt + 1;
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            slvCnt <= 0;
        else
            slvCnt <= slaveOe ? slvCnt + 1 : 0;
    end
    // remembers whether the last master pulse was a reset, to tell presence from a read zero
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            lastLen <= 0;
        else if (!masterOe && lowCnt != 0)
            lastLen <= lowCnt;
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_reset_end;
        $fell(masterOe) && lowCnt >= RESET_LOW_CYCLES;
    endsequence
    // slave stays quiet 15us, then starts presence before 60us
    sequence s_presence_start;
        (!slaveOe throughout (##300 1'b1)) ##[0:900] $rose(slaveOe);
    endsequence

    property p_recovery; $rose(masterOe) |-> relCnt >= US; endproperty
    a_recovery: assert property (p_recovery) else $error("slot began without recovery gap");
    property p_init_low; $fell(masterOe) |-> lowCnt >= US; endproperty
    a_init_low: assert property (p_init_low) else $error("master low pulse too short");
    property p_pulse_class; $fell(masterOe) |-> lowCnt <= 15 * US || lowCnt >= 60 * US; endproperty
    a_pulse_class: assert property (p_pulse_class) else $error("master low pulse length illegal");
    property p_reset_len; $fell(masterOe) && lowCnt > LONG_LOW |-> lowCnt >= RESET_LOW_CYCLES; endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset pulse shorter than minimum");
    property p_presence_reply; s_reset_end |-> s_presence_start; endproperty
    a_presence_reply: assert property (p_presence_reply) else $error("presence not in window");
    property p_slave_origin;
        $rose(slaveOe) && !$past(masterOe) |-> lastLen >= RESET_LOW_CYCLES && relCnt inside {[15 * US:60 * US]};
    endproperty
    a_slave_origin: assert property (p_slave_origin) else $error("slave drove outside a slot");
    property p_presence_len;
        $fell(slaveOe) && lastLen >= RESET_LOW_CYCLES |-> slvCnt inside {[60 * US:240 * US]};
    endproperty
    a_presence_len: assert property (p_presence_len) else $error("presence length illegal");
    property p_zero_hold;
        $fell(slaveOe) && lastLen < RESET_LOW_CYCLES |-> slvCnt inside {[15 * US:60 * US - 1]};
    endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("read zero held wrong length");
    property p_open_drain; !masterOut && !slaveOut && busLevel == !(masterOe || slaveOe); endproperty
    a_open_drain: assert property (p_open_drain) else $error("driver not open drain");
    property p_pullup_quiet; strongPullup |-> !masterOe && !slaveOe; endproperty
    a_pullup_quiet: assert property (p_pullup_quiet) else $error("line pulled low under strong pullup");
endmodule // wire_link_monitor

/* File: sim/tb.sv */
// self-checking bench: master and slave joined over the shared wire
`timescale 1ns/1ps
module tb;
    localparam int RESET_LOW = 3200; // shortened reset, still long enough to see presence end
    logic       mclk, reset, cmdValid, cmdReady, doneValid, presenceSeen, crcZero;
    logic       sendEn, sendBit, pollMode, opBusy, rxValid, rxBit, resetSeen, linkReady, oePrev, busPrev;
    logic [1:0] cmdOp;
    logic [7:0] cmdData, doneData, txReg, rxShift, wireShift;
    logic [7:0] cmdBytes [5] = '{8'h55, 8'hBE, 8'hB4, 8'h44, 8'hB8};
    int         errors, n_compared, rxCount, resetCount, fallAge, n;

    wire_link_if wire_link_if_i ();
    slot_master #(.RESET_LOW_CYCLES(RESET_LOW)) slot_master_i (.mclk(mclk), .reset(reset),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdData(cmdData), .cmdReady(cmdReady), .doneValid(doneValid),
        .doneData(doneData), .presenceSeen(presenceSeen), .crcZero(crcZero), .link(wire_link_if_i));
    slot_slave #(.RESET_DETECT_CYCLES(2800)) slot_slave_i (.mclk(mclk), .reset(reset), .sendEn(sendEn),
        .sendBit(sendBit), .pollMode(pollMode), .opBusy(opBusy), .rxValid(rxValid), .rxBit(rxBit),
        .resetSeen(resetSeen), .linkReady(linkReady), .link(wire_link_if_i));
    wire_link_monitor #(.RESET_LOW_CYCLES(RESET_LOW)) wire_link_monitor_i (.mclk(mclk), .reset(reset),
        .masterOut(wire_link_if_i.masterOut), .masterOe(wire_link_if_i.masterOe),
        .slaveOut(wire_link_if_i.slaveOut), .slaveOe(wire_link_if_i.slaveOe),
        .strongPullup(wire_link_if_i.strongPullup), .busLevel(wire_link_if_i.busLevel));

    // 20 MHz clock
    always #25 mclk = ~mclk;

    // observers; answer bits advance at each rise of the line so they are settled before the next fall
    always @(posedge mclk) begin
        if (rxValid === 1'b1) begin
            rxShift <= {rxBit, rxShift[7:1]};
            rxCount <= rxCount + 1;
        end
        if (resetSeen === 1'b1)
            resetCount <= resetCount + 1;
        fallAge <= (wire_link_if_i.masterOe && !oePrev) ? 0 : fallAge + 1;
        if (fallAge == 600)
            wireShift <= {wire_link_if_i.busLevel, wireShift[7:1]};
        oePrev <= wire_link_if_i.masterOe;
        busPrev <= wire_link_if_i.busLevel;
        if (wire_link_if_i.busLevel && !busPrev) begin
            sendBit <= txReg[0] ^ pollMode;
            opBusy <= !txReg[0];
            txReg <= txReg >> 1;
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one master command, waits for its done pulse under a bound
    task automatic do_cmd(input logic [1:0] op, input logic [7:0] data);
        int k;
        @(posedge mclk);
        cmdValid <= 1'b1;
        cmdOp <= op;
        cmdData <= data;
        @(posedge mclk);
        cmdValid <= 1'b0;
        k = 0;
        // the pullup op answers at the very edge that takes it, so look there first
        #1;
        while (doneValid !== 1'b1 && k < 20000) begin
            @(posedge mclk);
            #1;
            k++;
        end
        check("doneValid", 8'h01, {7'h00, doneValid});
    endtask

    // slave answers a read byte, from sendBit or from the busy flag in poll mode
    task automatic rd(input logic poll, input logic [7:0] b);
        @(posedge mclk);
        sendEn <= 1'b1;
        pollMode <= poll;
        txReg <= b >> 1;
        sendBit <= b[0] ^ poll;
        opBusy <= !b[0];
        do_cmd(wire_link_pkg::OP_READ, 8'h00);
        check("doneData", b, doneData);
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog, a little above the expected run length
    initial begin
        #(98000 * 50);
        errors++;
        final_report();
    end

    initial begin
        {mclk, cmdValid, cmdOp, cmdData, sendEn, sendBit, pollMode, opBusy, txReg} = '0;
        {errors, n_compared, rxCount, resetCount, fallAge} = '0;
        reset = 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        repeat (30) @(posedge mclk);
        do_cmd(wire_link_pkg::OP_RESET, 8'h00);
        check("presenceSeen", 8'h01, {7'h00, presenceSeen});
        check("linkReady", 8'h01, {7'h00, linkReady});
        check("crcZero", 8'h01, {7'h00, crcZero});
        check("resetSeen", 8'h01, 8'(resetCount));
        @(posedge mclk);
        #1;
        check("cmdReady", 8'h01, {7'h00, cmdReady});
        foreach (cmdBytes[i]) begin
            n = rxCount;
            do_cmd(wire_link_pkg::OP_WRITE, cmdBytes[i]);
            check("rxByte", cmdBytes[i], rxShift);
            check("wireByte", cmdBytes[i], wireShift);
            check("rxCount", 8'h08, 8'(rxCount - n));
        end
        rd(1'b0, 8'h3C);
        check("crcZero", 8'h00, {7'h00, crcZero});
        // poll answers carry the check byte of 3C, so the running check must return to zero
        rd(1'b1, 8'h1D);
        check("crcZero", 8'h01, {7'h00, crcZero});
        do_cmd(wire_link_pkg::OP_PULLUP, 8'h00);
        check("strongPullup", 8'h01, {7'h00, wire_link_if_i.strongPullup});
        @(posedge mclk);
        sendEn <= 1'b0;
        do_cmd(wire_link_pkg::OP_RESET, 8'h00);
        check("strongPullup", 8'h00, {7'h00, wire_link_if_i.strongPullup});
        check("resetSeen", 8'h02, 8'(resetCount));
        final_report();
    end
endmodule // tb
